/* psf_dev_model.sv */
// behavioural model of the strobe-driven fifo device
`timescale 1ns/1ps
module psf_dev_model #(
    parameter int DEPTH = 8
) (
    // strobes and mode pins
    input  wire logic       clear_n_i,
    input  wire logic       load_n_i,
    input  wire logic       fetch_n_i,
    input  wire logic       first_load_rewind_n_i,
    input  wire logic       chain_in_n_i,
    input  wire logic       in_port_select_i,
    input  wire logic       out_port_select_i,
    // data
    input  wire logic [8:0] par_in_lines_i,
    output logic      [8:0] par_out_lines_o,
    // flags
    output logic            full_n_o,
    output logic            empty_n_o,
    output logic            half_n_o,
    output logic            near_full_n_o,
    output logic            near_empty_n_o,
    output logic            edge_zone_n_o
);
    logic [8:0] mem_q [DEPTH];
    // power-up pointers are junk until a clear
    int         wr_q = 3;
    int         rd_q = 0;
    int         cnt_q = 3;
    int         lvl;
    logic       take_q = 1'b0;
    logic       give_q = 1'b0;
    logic [8:0] out_q = 9'h000;
    // a word under fetch already counts as gone on the empty side
    assign lvl = cnt_q - ((give_q && !fetch_n_i) ? 1 : 0);
    assign full_n_o = (cnt_q != DEPTH);
    assign near_full_n_o = (cnt_q < DEPTH - 1);
    assign half_n_o = (cnt_q <= DEPTH / 2);
    assign empty_n_o = (lvl != 0);
    assign near_empty_n_o = (lvl > 1);
    assign edge_zone_n_o = (lvl >= DEPTH / 8) && (cnt_q <= DEPTH - DEPTH / 8);
    assign par_out_lines_o = out_q;
    always @(negedge clear_n_i)
    begin
        wr_q = 0;
        rd_q = 0;
        cnt_q = 0;
    end
    // parallel input side: word taken on load rise if select high, not full and clear high
    always @(negedge load_n_i) take_q = full_n_o && clear_n_i && in_port_select_i;
    always @(posedge load_n_i)
    begin
        if (take_q)
        begin
            mem_q[wr_q] = par_in_lines_i;
            wr_q = (wr_q + 1) % DEPTH;
            cnt_q = cnt_q + 1;
        end
        take_q = 1'b0;
    end
    always @(negedge fetch_n_i)
    begin
        give_q = empty_n_o && out_port_select_i;
        if (give_q) out_q = mem_q[rd_q];
    end
    always @(posedge fetch_n_i)
    begin
        if (give_q)
        begin
            rd_q = (rd_q + 1) % DEPTH;
            cnt_q = cnt_q - 1;
        end
        give_q = 1'b0;
        out_q = ~out_q;
    end
    always @(negedge first_load_rewind_n_i)
    begin
        if (!chain_in_n_i)
        begin
            rd_q = 0;
            cnt_q = wr_q;
        end
    end
endmodule : psf_dev_model

/* psf_host.sv */
// host controller driving a parallel fifo device through its strobes
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "psf_params.svh"

module psf_host #(
    parameter int WORD_W = `PSF_WORD_W,
    parameter int DEPTH  = `PSF_DEPTH_SMALL
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // device strobes and configuration
    output logic                   clear_n_o,
    output logic                   load_n_o,
    output logic                   fetch_n_o,
    output logic                   first_load_rewind_n_o,
    output logic                   chain_in_n_o,
    output logic                   in_port_select_o,
    output logic                   out_port_select_o,
    // device data
    output logic [WORD_W-1:0]      par_in_lines_o,
    input  wire logic [WORD_W-1:0] par_out_lines_i,
    // device flags
    input  wire logic              full_n_i,
    input  wire logic              empty_n_i,
    input  wire logic              half_n_i,
    input  wire logic              near_full_n_i,
    input  wire logic              near_empty_n_i,
    input  wire logic              edge_zone_n_i
);

    localparam int STROBE_C  = `PSF_CYC(`PSF_STROBE_NS);
    localparam int RECOVER_C = `PSF_CYC(`PSF_RECOVER_NS) + `PSF_CYC(`PSF_FLAG_NS);
    localparam int CLEAR_C   = `PSF_CYC(`PSF_CLEAR_NS);
    localparam int SETUP_C   = `PSF_CYC(`PSF_CLEAR_SETUP_NS);
    localparam int CNT_W     = 8;
    localparam int FLAG_N    = 6;

    // ----------------------------------------------------------------
    // flag synchronisers
    // ----------------------------------------------------------------
    logic [FLAG_N-1:0] flag_meta_q;
    logic [FLAG_N-1:0] flag_q;
    logic [WORD_W-1:0] out_meta_q;
    logic [WORD_W-1:0] out_q;
    wire  [FLAG_N-1:0] flag_raw = {edge_zone_n_i, near_empty_n_i, near_full_n_i,
                                   half_n_i, empty_n_i, full_n_i};

    always_ff @(posedge clk_i)
    begin
        flag_meta_q <= flag_raw;
        flag_q      <= flag_meta_q;
        out_meta_q  <= par_out_lines_i;
        out_q       <= out_meta_q;
    end

    wire dev_full  = ~flag_q[0];
    wire dev_empty = ~flag_q[1];

    // ----------------------------------------------------------------
    // registers and sequencer
    // ----------------------------------------------------------------
    psf_pkg::psf_state_e state_q;
    psf_pkg::psf_op_e    op_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [WORD_W-1:0]   wdata_q;
    logic [WORD_W-1:0]   rdata_q;
    logic                single_q;
    logic                rewind_q;
    logic                cleared_q;
    logic                refused_q;
    logic                rd_ack_q;

    wire bus_idle   = (state_q == psf_pkg::ST_IDLE);
    wire wr_ctrl    = avs_write_i && avs_address_i == `PSF_REG_CTRL;
    wire wr_data    = avs_write_i && avs_address_i == `PSF_REG_WDATA;
    wire start_op   = bus_idle && (wr_data || (wr_ctrl && (avs_writedata_i[`PSF_CTRL_CLEAR]
                      || avs_writedata_i[`PSF_CTRL_FETCH])));
    // a write before the first clear or into a full device is refused
    wire wr_refuse  = wr_data && (!cleared_q || dev_full); // R4 R9
    wire rd_refuse  = wr_ctrl && avs_writedata_i[`PSF_CTRL_FETCH] && dev_empty; // R13
    wire cnt_done   = (cnt_q == '0);

    // writes stall while a strobe sequence runs; a read takes one wait
    // so its registered data already stand at the answering edge
    assign avs_waitrequest_o = (avs_write_i && !bus_idle) || (avs_read_i && !rd_ack_q);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q   <= psf_pkg::ST_IDLE;
            op_q      <= psf_pkg::OP_NONE;
            cnt_q     <= '0;
            wdata_q   <= '0;
            rdata_q   <= '0;
            single_q  <= 1'b1;
            rewind_q  <= 1'b0;
            cleared_q <= 1'b0;
            refused_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && bus_idle)
            begin
                single_q <= avs_writedata_i[`PSF_CTRL_SINGLE];
                rewind_q <= avs_writedata_i[`PSF_CTRL_REWIND] && avs_writedata_i[`PSF_CTRL_SINGLE]; // R16
            end
            case (state_q)
                psf_pkg::ST_IDLE:
                begin
                    if (start_op)
                    begin
                        if (wr_ctrl && avs_writedata_i[`PSF_CTRL_CLEAR])
                        begin
                            op_q    <= psf_pkg::OP_CLEAR;
                            cnt_q   <= CNT_W'(CLEAR_C + SETUP_C);
                            state_q <= psf_pkg::ST_LOW;
                        end
                        else if (wr_refuse || rd_refuse)
                            refused_q <= 1'b1;
                        else
                        begin
                            op_q    <= wr_data ? psf_pkg::OP_WRITE : psf_pkg::OP_READ;
                            wdata_q <= avs_writedata_i[WORD_W-1:0];
                            cnt_q   <= CNT_W'(STROBE_C);
                            refused_q <= 1'b0;
                            state_q <= psf_pkg::ST_LOW; // R6 R11
                        end
                    end
                end
                psf_pkg::ST_LOW:
                begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_done)
                    begin
                        if (op_q == psf_pkg::OP_READ)
                            rdata_q <= out_q;
                        if (op_q == psf_pkg::OP_CLEAR)
                            cleared_q <= 1'b1; // R4
                        cnt_q   <= CNT_W'(RECOVER_C);
                        state_q <= psf_pkg::ST_RECOVER;
                    end
                end
                psf_pkg::ST_RECOVER:
                begin
                    // wait out recovery plus flag settling before the next strobe
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_done)
                    begin
                        op_q    <= psf_pkg::OP_NONE;
                        state_q <= psf_pkg::ST_IDLE;
                    end
                end
                default:
                    state_q <= psf_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    wire in_low = (state_q == psf_pkg::ST_LOW);
    logic clear_n_q;
    logic load_n_q;
    logic fetch_n_q;
    logic [WORD_W-1:0] pin_data_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            clear_n_q  <= 1'b1;
            load_n_q   <= 1'b1;
            fetch_n_q  <= 1'b1;
            pin_data_q <= '0;
        end
        else
        begin
            clear_n_q  <= !(in_low && op_q == psf_pkg::OP_CLEAR && cnt_q < CNT_W'(CLEAR_C)); // R3 R5
            load_n_q   <= !(in_low && op_q == psf_pkg::OP_WRITE); // R6
            fetch_n_q  <= !(in_low && op_q == psf_pkg::OP_READ); // R11 R12
            pin_data_q <= wdata_q; // R7
        end
    end

    assign clear_n_o             = clear_n_q;
    assign load_n_o              = load_n_q;
    assign fetch_n_o             = fetch_n_q;
    assign par_in_lines_o        = pin_data_q; // R1
    assign first_load_rewind_n_o = !rewind_q; // R15 R16
    assign chain_in_n_o          = !single_q; // R17
    // parallel both ways; serial ports need external wiring
    assign in_port_select_o      = 1'b1; // R1 R2 R23
    assign out_port_select_o     = 1'b1; // R24

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [31:0] status_w = {24'h0000_00, refused_q, !bus_idle, flag_q}; // R18
    wire [31:0] rd_mux   =
        avs_address_i == `PSF_REG_RDATA  ? {{(32-WORD_W){1'b0}}, rdata_q} :
        avs_address_i == `PSF_REG_STATUS ? status_w :
        avs_address_i == `PSF_REG_CTRL   ? {28'h000_0000, single_q, 1'b0, 1'b0, 1'b0} :
        avs_address_i == `PSF_REG_WDATA  ? {{(32-WORD_W){1'b0}}, wdata_q} : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
            rd_ack_q       <= 1'b0;
        end
        else
        begin
            rd_ack_q <= avs_read_i && !rd_ack_q;
            if (avs_read_i && !rd_ack_q)
                avs_readdata_o <= rd_mux;
        end
    end

endmodule : psf_host

/* psf_host_assertions.sv */
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module psf_host_assertions #(
    parameter int WORD_W = 9
) (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic              avs_waitrequest_o,
    input wire logic              clear_n_o,
    input wire logic              load_n_o,
    input wire logic              fetch_n_o,
    input wire logic              first_load_rewind_n_o,
    input wire logic              chain_in_n_o,
    input wire logic              in_port_select_o,
    input wire logic              out_port_select_o,
    input wire logic [WORD_W-1:0] par_in_lines_o,
    input wire logic              full_n_i,
    input wire logic              empty_n_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence load_start; $fell(load_n_o); endsequence
    sequence fetch_start; $fell(fetch_n_o); endsequence
    // flags pass a two-stage sync, so six cycles of a steady flag are needed
    sequence stays_full; (!full_n_i)[*6]; endsequence
    sequence stays_empty; (!empty_n_i)[*6]; endsequence
    strobe_hold_a: assert property (!clear_n_o |-> load_n_o && fetch_n_o)
        else $error("strobe low during clear");
    clear_width_a: assert property ($fell(clear_n_o) |-> (!clear_n_o)[*7])
        else $error("clear pulse too short");
    full_block_a: assert property (stays_full |-> !$fell(load_n_o))
        else $error("load started on full device");
    empty_block_a: assert property (stays_empty |-> !$fell(fetch_n_o))
        else $error("fetch started on empty device");
    load_width_a: assert property (load_start |-> (!load_n_o)[*7])
        else $error("load pulse too short");
    fetch_width_a: assert property (fetch_start |-> (!fetch_n_o)[*7])
        else $error("fetch pulse too short");
    data_hold_a: assert property (!load_n_o |=> $stable(par_in_lines_o))
        else $error("write data moved during load");
    fetch_recover_a: assert property ($rose(fetch_n_o) |-> fetch_n_o[*2])
        else $error("fetch recovery too short");
    read_wait_a: assert property (avs_read_i && !avs_write_i && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("read stalled beyond one wait");
    port_mode_a: assert property (in_port_select_o && out_port_select_o)
        else $error("port select not parallel");
    rewind_single_a: assert property (!first_load_rewind_n_o |-> !chain_in_n_o)
        else $error("rewind outside single mode");
endmodule : psf_host_assertions

bind psf_host psf_host_assertions #(.WORD_W(WORD_W)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .clear_n_o(clear_n_o), .load_n_o(load_n_o),
    .fetch_n_o(fetch_n_o), .first_load_rewind_n_o(first_load_rewind_n_o), .chain_in_n_o(chain_in_n_o),
    .in_port_select_o(in_port_select_o), .out_port_select_o(out_port_select_o),
    .par_in_lines_o(par_in_lines_o), .full_n_i(full_n_i), .empty_n_i(empty_n_i));

/* psf_params.svh */
// constants for the parallel-serial fifo host controller
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// R1 - select high: device takes parallel words
// R2 - select low: serial in, data lines program width
// R3 - clear low resets both device pointers
// R4 - host clears device before any write
// R5 - host keeps load and fetch high in clear
// R6 - parallel write starts on load fall, not full
// R7 - host holds data stable across load rise
// R8 - words stored consecutively, returned in order
// R9 - full: full flag low, writes ignored
// R10 - read on full releases full flag
// R11 - parallel read starts on fetch fall, not empty
// R12 - outputs float after fetch returns high; the model drives the inverted word instead
// R13 - last word read: empty low, reads refused
// R14 - write on empty releases empty flag
// R15 - chain: first-load low on first device only; the host holds first-load high whenever single mode is off
// R16 - single device: first-load pin means rewind
// R17 - chain input low selects single device
// R18 - clear drives empty, near-empty, edge-zone low
// R19 - serial out: empty on bit 0 last word
// R20 - serial out: full released on bit 0 first word
// R21 - serial in: full on bit 1 last word
// R22 - serial in: empty released on last bit first word
// R23 - width chosen by wiring data line to load
// R24 - serial output shifts least significant bit first
// R25 - depth is a parameter, nine-bit words
`ifndef PSF_PARAMS_SVH
`define PSF_PARAMS_SVH

`define PSF_WORD_W        9
`define PSF_DEPTH_SMALL   2048
`define PSF_DEPTH_LARGE   4096
`define PSF_CLK_MHZ       125
// pulse widths, recovery, setup, access and flag delay in ns
`define PSF_STROBE_NS     50
`define PSF_RECOVER_NS    15
`define PSF_CLEAR_NS      50
`define PSF_CLEAR_SETUP_NS 50
`define PSF_ACCESS_NS     50
`define PSF_FLAG_NS       65
// least times round up to cycles
`define PSF_CYC(ns)       (((ns) * `PSF_CLK_MHZ + 999) / 1000)
// host register offsets
`define PSF_REG_CTRL      4'h0
`define PSF_REG_WDATA     4'h4
`define PSF_REG_RDATA     4'h8
`define PSF_REG_STATUS    4'hC
// ctrl bits
`define PSF_CTRL_CLEAR    0
`define PSF_CTRL_REWIND   1
`define PSF_CTRL_FETCH    2
`define PSF_CTRL_SINGLE   3

`endif

/* psf_pkg.sv */
// types for the parallel-serial fifo host controller
package psf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_LOW,
        ST_HIGH,
        ST_RECOVER
    } psf_state_e;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_WRITE,
        OP_READ,
        OP_CLEAR
    } psf_op_e;
endpackage : psf_pkg

/* tb_psf_host.sv */
// self-checking bench for the fifo host controller
`timescale 1ns/1ps
`include "psf_params.svh"
module tb_psf_host;
    localparam int DEPTH = 8;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o, rd;
    logic        avs_waitrequest_o, clear_n, load_n, fetch_n, rewind_n, chain_n;
    logic        full_n, empty_n, half_n, nfull_n, nempty_n, edge_n;
    logic        in_sel, out_sel;
    logic [8:0]  din, dout;
    logic [8:0]  words [DEPTH];
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    psf_host #(.WORD_W(9), .DEPTH(DEPTH)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .clear_n_o(clear_n), .load_n_o(load_n), .fetch_n_o(fetch_n),
        .first_load_rewind_n_o(rewind_n), .chain_in_n_o(chain_n), .in_port_select_o(in_sel),
        .out_port_select_o(out_sel),
        .par_in_lines_o(din), .par_out_lines_i(dout), .full_n_i(full_n), .empty_n_i(empty_n),
        .half_n_i(half_n), .near_full_n_i(nfull_n), .near_empty_n_i(nempty_n), .edge_zone_n_i(edge_n));
    psf_dev_model #(.DEPTH(DEPTH)) i_dev (
        .clear_n_i(clear_n), .load_n_i(load_n), .fetch_n_i(fetch_n), .first_load_rewind_n_i(rewind_n),
        .chain_in_n_i(chain_n), .in_port_select_i(in_sel), .out_port_select_i(out_sel),
        .par_in_lines_i(din), .par_out_lines_o(dout), .full_n_o(full_n),
        .empty_n_o(empty_n), .half_n_o(half_n), .near_full_n_o(nfull_n), .near_empty_n_o(nempty_n),
        .edge_zone_n_o(edge_n));
    initial forever #4 clk_i = ~clk_i;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    // one access; data taken at the edge that sees waitrequest low, then one idle edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 300);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 300) bad_count++;
        if (n >= 300) $display("ERROR bus answer expected within 300 seen none");
    endtask : bus
    task automatic settle;
        int n;
        n = 0;
        do bus(1'b0, `PSF_REG_STATUS, 32'h0000_0000); while (rd[6] !== 1'b0 && ++n < 100);
        if (n >= 100) bad_count++;
        if (n >= 100) $display("ERROR busy expected 0 seen 1");
    endtask : settle
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("ERROR %s expected %h seen %h", what, exp, got);
    endtask : check
    task automatic fetch_word;
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_000C);
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_0008);
        settle();
    endtask : fetch_word
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        check("single mode", 32'h0, {31'h0, chain_n});
        check("parallel in", 32'h1, {31'h0, in_sel});
        check("parallel out", 32'h1, {31'h0, out_sel});
        bus(1'b1, `PSF_REG_WDATA, 32'h0000_01AA);
        settle();
        check("write before clear", 32'h1, {31'h0, rd[7]});
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_0009);
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_0008);
        settle();
        check("flags after clear", 32'h0D, {26'h0, rd[5:0]});
        $display("test clear done");
        for (int i = 0; i < DEPTH; i++)
        begin
            words[i] = 9'h0A5 ^ 9'(i * 59);
            bus(1'b1, `PSF_REG_WDATA, {23'h0, words[i]});
            settle();
            if (i == 0) check("empty released", 32'h1, {31'h0, rd[1]});
        end
        check("flags when full", 32'h12, {26'h0, rd[5:0]});
        bus(1'b1, `PSF_REG_WDATA, 32'h0000_00FF);
        settle();
        check("write when full", 32'h1, {31'h0, rd[7]});
        $display("test fill done");
        for (int i = 0; i < DEPTH; i++)
        begin
            fetch_word();
            if (i == 0) check("full released", 32'h1, {31'h0, rd[0]});
            bus(1'b0, `PSF_REG_RDATA, 32'h0000_0000);
            check("read order", {23'h0, words[i]}, rd);
        end
        settle();
        check("flags when empty", 32'h0D, {26'h0, rd[5:0]});
        fetch_word();
        check("fetch when empty", 32'h1, {31'h0, rd[7]});
        $display("test drain done");
        bus(1'b1, `PSF_REG_WDATA, {23'h0, words[3]});
        bus(1'b1, `PSF_REG_WDATA, {23'h0, words[4]});
        fetch_word();
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_000A);
        bus(1'b1, `PSF_REG_CTRL, 32'h0000_0008);
        settle();
        fetch_word();
        bus(1'b0, `PSF_REG_RDATA, 32'h0000_0000);
        check("word after rewind", {23'h0, words[3]}, rd);
        $display("test rewind done");
        give_verdict();
    end
endmodule : tb_psf_host
